/* include/qsr_pkg.sv */
// Package with constants, opcodes and carriers of the quality status block
package qsr_pkg;

    // Register width and number of condition inputs
    localparam int REG_WIDTH   = 16;
    localparam int NUM_COND    = 6;

    // Bit positions of the quality conditions
    localparam int BIT_POWER   = 3;
    localparam int BIT_OVEN    = 4;
    localparam int BIT_LOCK    = 5;
    localparam int BIT_ZERO    = 6;
    localparam int BIT_MOD     = 7;
    localparam int BIT_CAL     = 8;
    localparam int BIT_OVLD    = 9;

    // Meaningful bits: 3-5 and 7-9
    localparam logic [15:0] USED_MASK   = 16'h03B8;

    // Summary position in the status byte
    localparam int SUMMARY_BIT = 3;

    // Reset values of the stored registers
    localparam logic [15:0] ENABLE_RST  = 16'h0000;
    localparam logic [15:0] FALL_RST    = 16'h0000;
    localparam logic [15:0] RISE_RST    = 16'h0000;
    localparam logic [15:0] EVENT_RST   = 16'h0000;

    // Status command opcodes
    typedef enum logic [3:0] {
        OP_NOP      = 4'h0,
        OP_CLEAR    = 4'h1,
        OP_WR_EN    = 4'h2,
        OP_WR_FALL  = 4'h3,
        OP_WR_RISE  = 4'h4,
        OP_RD_COND  = 4'h5,
        OP_RD_EVENT = 4'h6,
        OP_RD_EN    = 4'h7,
        OP_RD_FALL  = 4'h8,
        OP_RD_RISE  = 4'h9
    } qsr_op_type;

    // Command from the remote controller side
    typedef struct packed {
        logic             valid;
        qsr_op_type       op;
        logic [15:0]      data;
    } qsr_req_type;

    // Answer to a query
    typedef struct packed {
        logic             valid;
        logic [15:0]      data;
    } qsr_rsp_type;

    // Places the six condition inputs at their register positions
    function automatic logic [15:0] qsr_expand_cond(input logic [5:0] c);
        logic [15:0] r;
        r            = 16'h0000;
        r[BIT_POWER] = c[0];
        r[BIT_OVEN]  = c[1];
        r[BIT_LOCK]  = c[2];
        r[BIT_MOD]   = c[3];
        r[BIT_CAL]   = c[4];
        r[BIT_OVLD]  = c[5];
        return r;
    endfunction : qsr_expand_cond

endpackage : qsr_pkg

/* rtl/qsr_cond_sync.sv */
// Three-stage synchroniser with agreement filter for condition pins
`timescale 1ns/1ns
module qsr_cond_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             ref_clk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a bit change only once stages two and three agree
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            level_out <= '0;
        else
            for (int i = 0; i < WIDTH; i++)
                if (s2_q[i] == s3_q[i])
                    level_out[i] <= s3_q[i];
    end

endmodule : qsr_cond_sync

/* rtl/qsr_status.sv */
// Signal quality status group: condition, filters, events, summary
`timescale 1ns/1ns
module qsr_status #(
    parameter int NUM_COND = qsr_pkg::NUM_COND
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  srst_in,
    input  wire logic [NUM_COND-1:0]   cond_in,
    input  wire qsr_pkg::qsr_req_type  req_in,
    output qsr_pkg::qsr_rsp_type       rsp_out,
    output logic                       summary_out
);

    logic [NUM_COND-1:0] cond_lvl;
    logic [15:0]         cond_now;
    logic [15:0]         cond_prev_q;
    logic [15:0]         enable_q;
    logic [15:0]         fall_q;
    logic [15:0]         rise_q;
    logic [15:0]         event_q;
    logic [15:0]         event_d;
    logic [15:0]         rise_hit;
    logic [15:0]         fall_hit;
    logic                ev_clear;
    logic                is_wr;

    // Condition pins cross into the clock domain
    qsr_cond_sync #(
        .WIDTH      (NUM_COND)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .raw_in     (cond_in),
        .level_out  (cond_lvl)
    );

    // Position the conditions; bit 6 and unused bits stay zero
    assign cond_now = qsr_pkg::qsr_expand_cond(cond_lvl);

    // Previous-cycle copy for edge detection
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            cond_prev_q <= 16'h0000;
        else
            cond_prev_q <= cond_now;
    end

    // Filtered edges, only at the meaningful positions
    assign rise_hit = cond_now & ~cond_prev_q & rise_q
                      & qsr_pkg::USED_MASK;
    assign fall_hit = ~cond_now & cond_prev_q & fall_q
                      & qsr_pkg::USED_MASK;

    assign is_wr = req_in.valid;

    // Software-written registers keep every written bit for readback
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            enable_q <= qsr_pkg::ENABLE_RST;
            fall_q   <= qsr_pkg::FALL_RST;
            rise_q   <= qsr_pkg::RISE_RST;
        end
        else if (is_wr)
        begin
            case (req_in.op)
                qsr_pkg::OP_WR_EN:   enable_q <= req_in.data;
                qsr_pkg::OP_WR_FALL: fall_q   <= req_in.data;
                qsr_pkg::OP_WR_RISE: rise_q   <= req_in.data;
                default:             ;
            endcase
        end
    end

    // Event clear by query or clear-status; new edges win over the clear
    assign ev_clear = req_in.valid
                      && (req_in.op == qsr_pkg::OP_RD_EVENT
                          || req_in.op == qsr_pkg::OP_CLEAR);
    assign event_d  = (ev_clear ? 16'h0000 : event_q)
                      | rise_hit | fall_hit;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            event_q <= qsr_pkg::EVENT_RST;
        else
            event_q <= event_d;
    end

    // Query answers, one cycle after the command
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            rsp_out.valid <= 1'b0;
            rsp_out.data  <= 16'h0000;
        end
        else
        begin
            rsp_out.valid <= 1'b0;
            if (req_in.valid)
            begin
                case (req_in.op)
                    qsr_pkg::OP_RD_COND:
                    begin
                        rsp_out.valid <= 1'b1;
                        rsp_out.data  <= cond_now;
                    end
                    qsr_pkg::OP_RD_EVENT:
                    begin
                        rsp_out.valid <= 1'b1;
                        rsp_out.data  <= event_q;
                    end
                    qsr_pkg::OP_RD_EN:
                    begin
                        rsp_out.valid <= 1'b1;
                        rsp_out.data  <= enable_q;
                    end
                    qsr_pkg::OP_RD_FALL:
                    begin
                        rsp_out.valid <= 1'b1;
                        rsp_out.data  <= fall_q;
                    end
                    qsr_pkg::OP_RD_RISE:
                    begin
                        rsp_out.valid <= 1'b1;
                        rsp_out.data  <= rise_q;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Summary bit 3 of the status byte from enabled events
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            summary_out <= 1'b0;
        else
            summary_out <= |(event_q & enable_q
                             & qsr_pkg::USED_MASK);
    end

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    a_summary_follows: assert property (
        ##1 summary_out == $past(|(event_q & enable_q & 16'h03B8)))
        else $error("summary bit does not follow enabled events");

    a_mask_dont_care: assert property (
        ((event_q & enable_q & 16'h03B8) == 16'h0000)
        |=> !summary_out)
        else $error("summary raised by an unused mask bit");

    a_event_unused_zero: assert property (
        (event_q & ~16'h03B8) == 16'h0000)
        else $error("event bit set outside used positions");

    a_enable_readback: assert property (
        (req_in.valid && req_in.op == qsr_pkg::OP_WR_EN)
        ##1 (req_in.valid && req_in.op == qsr_pkg::OP_RD_EN)
        |=> rsp_out.valid && rsp_out.data == $past(req_in.data, 2))
        else $error("enable mask readback differs from write");

    a_event_read_clear: assert property (
        (req_in.valid && req_in.op == qsr_pkg::OP_RD_EVENT
         && rise_hit == 16'h0000 && fall_hit == 16'h0000)
        |=> event_q == 16'h0000 && rsp_out.data == $past(event_q))
        else $error("event query did not return and clear");

    a_clear_status: assert property (
        (req_in.valid && req_in.op == qsr_pkg::OP_CLEAR
         && (rise_hit | fall_hit) == 16'h0000)
        |=> event_q == 16'h0000)
        else $error("clear-status left event bits set");

    a_event_sticky: assert property (
        !ev_clear |=> (event_q & $past(event_q)) == $past(event_q))
        else $error("event bit dropped without a clear");

    a_fall_sets: assert property (
        (fall_hit != 16'h0000) |=> (event_q & $past(fall_hit))
                                   == $past(fall_hit))
        else $error("filtered falling edge missed");

    a_rise_sets: assert property (
        (rise_hit != 16'h0000) |=> (event_q & $past(rise_hit))
                                   == $past(rise_hit))
        else $error("filtered rising edge missed");

    a_cond_read_clean: assert property (
        (req_in.valid && req_in.op == qsr_pkg::OP_RD_COND)
        |=> rsp_out.valid && (rsp_out.data & ~16'h03B8) == 16'h0000)
        else $error("condition answer has unused bits set");

    c_rise_event: cover property (rise_hit != 16'h0000 ##1 summary_out);
    c_fall_event: cover property (fall_hit != 16'h0000);
    c_read_clear: cover property (
        event_q != 16'h0000 && req_in.valid
        && req_in.op == qsr_pkg::OP_RD_EVENT);
    c_set_on_clear: cover property (ev_clear && (rise_hit | fall_hit) != 0);

endmodule : qsr_status

/* test/qsr_remote_model.sv */
// Remote controller model issuing status commands and collecting answers
`timescale 1ns/1ns
module qsr_remote_model (
    input  wire logic                 ref_clk_in,
    output qsr_pkg::qsr_req_type      req_out,
    input  wire qsr_pkg::qsr_rsp_type rsp_in
);
    // No command at time zero
    initial req_out = '0;
    // Raises one command for one sampled edge, then releases it
    task automatic send(input qsr_pkg::qsr_op_type op, input logic [15:0] d);
        @(posedge ref_clk_in);
        req_out <= {1'b1, op, d};
        @(posedge ref_clk_in);
        req_out <= {1'b0, ~op, ~d}; // Released: leftovers shown inverted
    endtask : send
    // Query with a bounded wait for the answer
    task automatic query(input qsr_pkg::qsr_op_type op,
                         output logic [15:0] d);
        int n;
        n = 0;
        send(op, 16'h0000);
        #1;
        while (rsp_in.valid !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        d = (rsp_in.valid === 1'b1) ? rsp_in.data : 'x;
    endtask : query
    // Write, then a query in the very next cycle; answer taken at its edge
    task automatic write_read(input qsr_pkg::qsr_op_type wop,
                              input logic [15:0] wd,
                              input qsr_pkg::qsr_op_type rop,
                              output logic [15:0] d);
        @(posedge ref_clk_in);
        req_out <= {1'b1, wop, wd};
        @(posedge ref_clk_in);
        req_out <= {1'b1, rop, 16'h0000};
        @(posedge ref_clk_in);
        req_out <= {1'b0, ~rop, 16'hFFFF};
        #1;
        d = (rsp_in.valid === 1'b1) ? rsp_in.data : 'x;
    endtask : write_read
endmodule : qsr_remote_model

/* test/qsr_status_tb.sv */
// Self-checking bench of the quality status group
`timescale 1ns/1ns
module qsr_status_tb;
    logic                 ref_clk_in;
    logic                 srst_in;
    logic [5:0]           cond_in;
    qsr_pkg::qsr_req_type req;
    qsr_pkg::qsr_rsp_type rsp;
    logic                 summary;
    int                   err_total;
    int                   n_compared;
    logic [31:0]          seed;
    logic [15:0]          m_en, m_fall, m_rise, m_ev, m_cond;
    int                   pos[6] = '{3, 4, 5, 7, 8, 9};
    logic [15:0]          rb;

    qsr_status u_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .cond_in(cond_in), .req_in(req), .rsp_out(rsp),
        .summary_out(summary));
    qsr_remote_model u_host (.ref_clk_in(ref_clk_in), .req_out(req),
        .rsp_in(rsp));

    // Pseudo-random source
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt
    // Places the six pins at their register positions
    function automatic logic [15:0] spread(input logic [5:0] c);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 6; i++) r[pos[i]] = c[i];
        return r;
    endfunction : spread
    // Compares one value
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Query and compare the answer
    task automatic rd(input qsr_pkg::qsr_op_type op, input logic [15:0] e);
        logic [15:0] d;
        u_host.query(op, d);
        check(d, e);
    endtask : rd
    // New pin levels; model latches filtered edges once settled
    task automatic set_cond(input logic [5:0] c);
        logic [15:0] n;
        n = spread(c);
        @(posedge ref_clk_in);
        cond_in <= c;
        repeat (8) @(posedge ref_clk_in);
        #1;
        m_ev = m_ev | (m_rise & n & ~m_cond) | (m_fall & m_cond & ~n);
        m_ev = m_ev & qsr_pkg::USED_MASK;
        m_cond = n;
    endtask : set_cond
    // Summary against the model
    task automatic chk_sum();
        check({15'h0000, summary},
              {15'h0000, |(m_ev & m_en & qsr_pkg::USED_MASK)});
    endtask : chk_sum
    // Verdict and end of run
    task automatic test_done();
        $display("compared=%0d mismatches=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // Clock
    initial
    begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // Watchdog, well beyond the roughly 440 cycles of the tests
    initial
    begin
        #500000;
        err_total++;
        test_done();
    end
    // Main sequence
    initial
    begin
        err_total = 0;
        n_compared = 0;
        seed = 32'h6CF697A6;
        srst_in = 1'b1;
        cond_in = 6'h00;
        {m_en, m_fall, m_rise, m_ev, m_cond} = '0;
        repeat (6) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        rd(qsr_pkg::OP_RD_EVENT, 16'h0000);
        rd(qsr_pkg::OP_RD_EN, 16'h0000);
        for (int k = 0; k < 14; k++)
        begin
            seed = nxt(seed);
            m_en = seed[15:0];
            m_fall = seed[31:16];
            seed = nxt(seed);
            m_rise = seed[15:0];
            u_host.write_read(qsr_pkg::OP_WR_EN, m_en,
                              qsr_pkg::OP_RD_EN, rb);
            check(rb, m_en);
            u_host.send(qsr_pkg::OP_WR_FALL, m_fall);
            u_host.send(qsr_pkg::OP_WR_RISE, m_rise);
            rd(qsr_pkg::OP_RD_EN, m_en);
            rd(qsr_pkg::OP_RD_FALL, m_fall);
            rd(qsr_pkg::OP_RD_RISE, m_rise);
            set_cond(seed[21:16]);
            rd(qsr_pkg::OP_RD_COND, m_cond);
            rd(qsr_pkg::OP_RD_COND, m_cond);
            chk_sum();
            if (k % 4 == 3)
            begin
                u_host.send(qsr_pkg::OP_CLEAR, 16'h0000);
                m_ev = 16'h0000;
                rd(qsr_pkg::OP_RD_EVENT, 16'h0000);
            end
            else if (k % 2 == 1)
            begin
                rd(qsr_pkg::OP_RD_EVENT, m_ev);
                m_ev = 16'h0000;
                rd(qsr_pkg::OP_RD_EVENT, 16'h0000);
                repeat (2) @(posedge ref_clk_in);
                #1;
                chk_sum();
            end
        end
        // Mid-run reset: stored registers return to their reset values
        @(posedge ref_clk_in);
        srst_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
        m_en = qsr_pkg::ENABLE_RST;
        m_fall = qsr_pkg::FALL_RST;
        m_rise = qsr_pkg::RISE_RST;
        m_ev = qsr_pkg::EVENT_RST;
        m_cond = spread(cond_in);
        rd(qsr_pkg::OP_RD_EN, m_en);
        rd(qsr_pkg::OP_RD_FALL, m_fall);
        rd(qsr_pkg::OP_RD_RISE, m_rise);
        rd(qsr_pkg::OP_RD_COND, m_cond);
        chk_sum();
        // Every used rising edge after the reset must latch
        m_rise = qsr_pkg::USED_MASK;
        u_host.send(qsr_pkg::OP_WR_RISE, m_rise);
        set_cond(~cond_in);
        rd(qsr_pkg::OP_RD_EVENT, m_ev);
        test_done();
    end
endmodule : qsr_status_tb
